/* File: cascaded_watchdog_consts.svh */
`ifndef CASCADED_WATCHDOG_CONSTS_SVH
`define CASCADED_WATCHDOG_CONSTS_SVH

// Host I/O window of four byte locations
`define WD_IO_BASE 10'h25C
`define WD_OFF_TRIGGER 2'h0
`define WD_OFF_DURATION 2'h1
`define WD_OFF_CONTROL 2'h2
`define WD_OFF_ENABLE 2'h3

// Trigger location
`define WD_TRIG_BIT 4

// Duration location: primary in the high nibble, secondary in the low nibble
`define WD_PRIM_MSB 7
`define WD_PRIM_LSB 4
`define WD_SEC_MSB 3
`define WD_SEC_LSB 0

// Control location
`define WD_CTL_TRIG_EN 7
`define WD_CTL_EARLY 6
`define WD_CTL_SMI 5
`define WD_CTL_EDGE 4
`define WD_CTL_RST 3

// Enable location
`define WD_EN_BIT 4

// Reset values
`define WD_DURATION_RST 8'h00
`define WD_CONTROL_RST 8'h00
`define WD_ENABLE_RST 8'h00
`define WD_RDATA_IDLE 8'h00

// Timing
`define WD_TICK_MS 145
`define WD_CLK_KHZ 200000
`define WD_TICK_CYCLES (`WD_TICK_MS * `WD_CLK_KHZ)

`endif

/* File: cascaded_watchdog_pkg.sv */
`default_nettype none

package cascaded_watchdog_pkg;
    typedef logic [3:0] ticks_t;
    typedef logic [7:0] io_byte_t;
    typedef logic [31:0] div_t;
endpackage : cascaded_watchdog_pkg

`default_nettype wire

/* File: countdown_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface countdown_if;
    logic load;
    logic stop;
    logic tick;
    cascaded_watchdog_pkg::ticks_t preset;
    cascaded_watchdog_pkg::ticks_t count;
    logic running;
    logic expired;
    modport ctrl(output load, output stop, output tick, output preset,
                 input count, input running, input expired);
    modport unit(input load, input stop, input tick, input preset,
                 output count, output running, output expired);
endinterface : countdown_if

`default_nettype wire

/* File: countdown_unit.sv */
`timescale 1ns/1ps
`default_nettype none

module countdown_unit (
    input wire logic clk,
    input wire logic rst,
    countdown_if.unit cd
);
    cascaded_watchdog_pkg::ticks_t count;
    cascaded_watchdog_pkg::ticks_t next_count;
    logic running;
    logic next_running;
    logic expired;
    logic next_expired;

    always_comb begin
        next_count = count;
        next_running = running;
        next_expired = 1'b0;
        if (cd.load) begin
            next_count = cd.preset;
            next_running = 1'b1;
        end else if (cd.stop) begin
            next_running = 1'b0;
        end else if (running && cd.tick) begin
            // A preset of zero expires on the first tick
            if (count <= 4'h1) begin
                next_count = 4'h0;
                next_running = 1'b0;
                next_expired = 1'b1;
            end else begin
                next_count = count - 4'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            count <= 4'h0;
            running <= 1'b0;
            expired <= 1'b0;
        end else begin
            count <= next_count;
            running <= next_running;
            expired <= next_expired;
        end
    end

    assign cd.count = count;
    assign cd.running = running;
    assign cd.expired = expired;

    AST_UNIT_LOAD: assert property (@(posedge clk) disable iff (rst)
        cd.load |=> running && count == $past(cd.preset))
        else $error("Countdown did not load its preset");

    AST_UNIT_EXPIRE: assert property (@(posedge clk) disable iff (rst)
        running && cd.tick && !cd.load && !cd.stop && count <= 4'h1 |=> expired && !running && count == 4'h0)
        else $error("Countdown did not expire at zero");

endmodule : countdown_unit

`default_nettype wire

/* File: cascaded_watchdog_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cascaded_watchdog_consts.svh"

module cascaded_watchdog_timer #(
    parameter int TICK_CYCLES = `WD_TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [9:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    input wire logic trigger_input,
    output logic alarm_output,
    output logic system_management_interrupt,
    output logic hw_reset
);
    localparam logic [9:0] IO_BASE = `WD_IO_BASE;

    if (TICK_CYCLES < 2) begin : g_bad_tick
        $error("TICK_CYCLES must be at least 2");
    end

    countdown_if prim();
    countdown_if sec();

    countdown_unit u_primary (
        .clk(clk),
        .rst(rst),
        .cd(prim)
    );

    countdown_unit u_secondary (
        .clk(clk),
        .rst(rst),
        .cd(sec)
    );

    // Host I/O registers
    cascaded_watchdog_pkg::io_byte_t duration;
    cascaded_watchdog_pkg::io_byte_t next_duration;
    cascaded_watchdog_pkg::io_byte_t control;
    cascaded_watchdog_pkg::io_byte_t next_control;
    cascaded_watchdog_pkg::io_byte_t enable_reg;
    cascaded_watchdog_pkg::io_byte_t next_enable_reg;
    cascaded_watchdog_pkg::io_byte_t next_io_rdata;
    logic hit;
    logic [1:0] offset;
    logic sw_trigger;

    assign hit = io_addr[9:2] == IO_BASE[9:2];
    assign offset = io_addr[1:0];
    assign sw_trigger = io_wr && hit && offset == `WD_OFF_TRIGGER && io_wdata[`WD_TRIG_BIT];

    always_comb begin
        next_duration = duration;
        next_control = control;
        next_enable_reg = enable_reg;
        next_io_rdata = `WD_RDATA_IDLE;
        if (io_wr && hit) begin
            case (offset)
                `WD_OFF_DURATION: next_duration = io_wdata;
                `WD_OFF_CONTROL: next_control = io_wdata;
                `WD_OFF_ENABLE: next_enable_reg = io_wdata;
                default: next_duration = duration;
            endcase
        end
        if (io_rd && hit) begin
            case (offset)
                `WD_OFF_CONTROL: next_io_rdata = control;
                `WD_OFF_ENABLE: next_io_rdata = enable_reg;
                default: next_io_rdata = `WD_RDATA_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            duration <= `WD_DURATION_RST;
            control <= `WD_CONTROL_RST;
            enable_reg <= `WD_ENABLE_RST;
            io_rdata <= `WD_RDATA_IDLE;
        end else begin
            duration <= next_duration;
            control <= next_control;
            enable_reg <= next_enable_reg;
            io_rdata <= next_io_rdata;
        end
    end

    logic wd_en;
    logic trig_pin_en;
    logic early_en;
    logic smi_sel;
    logic rise_sel;
    logic rst_sel;

    assign wd_en = enable_reg[`WD_EN_BIT];
    assign trig_pin_en = control[`WD_CTL_TRIG_EN];
    assign early_en = control[`WD_CTL_EARLY];
    assign smi_sel = control[`WD_CTL_SMI];
    assign rise_sel = control[`WD_CTL_EDGE];
    assign rst_sel = control[`WD_CTL_RST];

    // Trigger pin synchroniser and edge detector
    logic trig_meta;
    logic trig_sync;
    logic trig_prev;
    logic hw_edge;
    logic retrig;

    always_ff @(posedge clk) begin
        if (rst) begin
            trig_meta <= 1'b0;
            trig_sync <= 1'b0;
            trig_prev <= 1'b0;
        end else begin
            trig_meta <= trigger_input;
            trig_sync <= trig_meta;
            trig_prev <= trig_sync;
        end
    end

    // Edge polarity is selectable
    assign hw_edge = trig_pin_en && (rise_sel ? (trig_sync && !trig_prev) : (!trig_sync && trig_prev));
    assign retrig = wd_en && (sw_trigger || hw_edge);

    // Tick divider, restarted on every retrigger so the first period is whole
    cascaded_watchdog_pkg::div_t div;
    cascaded_watchdog_pkg::div_t next_div;
    logic tick;

    assign tick = div == 32'(TICK_CYCLES - 1);

    always_comb begin
        if (retrig || !wd_en || tick) begin
            next_div = 32'h0;
        end else begin
            next_div = div + 32'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            div <= 32'h0;
        end else begin
            div <= next_div;
        end
    end

    // Cascade control
    logic prim_fire;
    logic sec_fire;

    assign prim_fire = wd_en && !retrig && prim.expired;
    assign sec_fire = wd_en && !retrig && sec.expired;

    assign prim.load = retrig;
    assign prim.stop = !wd_en;
    assign prim.tick = tick;
    assign prim.preset = duration[`WD_PRIM_MSB:`WD_PRIM_LSB];
    assign sec.load = prim_fire;
    assign sec.stop = !wd_en || retrig;
    assign sec.tick = tick;
    assign sec.preset = duration[`WD_SEC_MSB:`WD_SEC_LSB];

    // Event outputs; the alarm holds so outside logic can respond during the second countdown
    logic next_alarm;
    logic next_smi;
    logic next_hw_reset;

    always_comb begin
        next_alarm = alarm_output;
        if (!wd_en || retrig) begin
            next_alarm = 1'b0;
        end else if (prim.expired) begin
            next_alarm = 1'b1;
        end else if (early_en && prim.running && prim.count == 4'h1) begin
            next_alarm = 1'b1;
        end
        next_smi = prim_fire && smi_sel;
        next_hw_reset = (prim_fire && rst_sel) || sec_fire;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            alarm_output <= 1'b0;
            system_management_interrupt <= 1'b0;
            hw_reset <= 1'b0;
        end else begin
            alarm_output <= next_alarm;
            system_management_interrupt <= next_smi;
            hw_reset <= next_hw_reset;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    AST_RETRIG_RELOAD: assert property (
        retrig |=> prim.running && prim.count == $past(prim.preset) && !sec.running && !alarm_output)
        else $error("Retrigger did not reload and clear the cascade");

    AST_SEC_START: assert property (
        prim_fire |=> sec.running && sec.count == $past(duration[`WD_SEC_MSB:`WD_SEC_LSB]) && alarm_output)
        else $error("Second countdown or alarm missing after first expiry");

    AST_SMI_SELECT: assert property (
        prim_fire |=> system_management_interrupt == $past(smi_sel) && (hw_reset == $past(rst_sel)))
        else $error("Interrupt or reset selection not honoured");

    AST_SMI_CAUSE: assert property (
        system_management_interrupt |-> $past(prim.expired) && $past(smi_sel))
        else $error("Interrupt without first expiry");

    AST_SEC_RESET: assert property (
        sec_fire |=> hw_reset)
        else $error("Second expiry did not force reset");

    AST_PIN_TRIGGER: assert property (
        wd_en && trig_pin_en && rise_sel && !trig_prev && trig_sync |=> prim.running && !alarm_output)
        else $error("Rising pin edge did not retrigger");

    AST_EARLY_ALARM: assert property (
        wd_en && !retrig && early_en && prim.running && prim.count == 4'h1 && !prim.load |=> alarm_output)
        else $error("Early alarm not raised at count one");

    AST_IO_READBACK: assert property (
        io_rd && hit && offset == `WD_OFF_CONTROL |=> io_rdata == $past(control))
        else $error("Control readback mismatch");

    AST_DISABLED_QUIET: assert property (
        !wd_en |=> !alarm_output && !hw_reset && !system_management_interrupt && !prim.running && !sec.running)
        else $error("Disabled watchdog still active");

endmodule : cascaded_watchdog_timer

`default_nettype wire

/* File: host_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Far side of the alarm/trigger pins: either a wire loop or a held level
module host_pin_model (
    input wire logic clk,
    input wire logic loop_en,
    input wire logic level,
    input wire logic alarm_output,
    output logic trigger_input
);
    logic next_pin;

    always_comb begin
        next_pin = loop_en ? alarm_output : level;
    end

    always_ff @(posedge clk) begin
        trigger_input <= next_pin;
    end
endmodule : host_pin_model

`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cascaded_watchdog_consts.svh"

module testbench;
    localparam int T = 4;
    typedef struct {logic [9:0] a; logic [7:0] wd; logic [7:0] rd;} row_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [9:0] io_addr = 10'h000;
    logic io_wr = 1'b0;
    logic io_rd = 1'b0;
    logic [7:0] io_wdata = 8'h00;
    logic [7:0] io_rdata;
    logic trigger_input;
    logic alarm_output;
    logic system_management_interrupt;
    logic hw_reset;
    logic loop_en = 1'b0;
    logic level = 1'b0;
    int bad_count = 0;
    int checked = 0;
    int smi_n = 0;
    int rst_n = 0;
    row_t rows[5] = '{'{10'h25E, 8'hA5, 8'hA5}, '{10'h25F, 8'hE0, 8'hE0}, '{10'h25C, 8'h10, 8'h00},
                      '{10'h25D, 8'h21, 8'h00}, '{10'h15E, 8'h00, 8'h00}};

    always #2.5 clk = ~clk;

    cascaded_watchdog_timer #(.TICK_CYCLES(T)) dut_u (.clk(clk), .rst(rst), .io_addr(io_addr),
        .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .trigger_input(trigger_input), .alarm_output(alarm_output),
        .system_management_interrupt(system_management_interrupt), .hw_reset(hw_reset));

    host_pin_model pin_u (.clk(clk), .loop_en(loop_en), .level(level),
        .alarm_output(alarm_output), .trigger_input(trigger_input));

    always @(posedge clk) begin
        if (system_management_interrupt === 1'b1) smi_n++;
        if (hw_reset === 1'b1) rst_n++;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %0h seen %0h", name, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk);
        io_addr <= a;
        io_wdata <= d;
        io_wr <= 1'b1;
        @(posedge clk);
        io_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [9:0] a, input logic [7:0] exp);
        @(posedge clk);
        io_addr <= a;
        io_rd <= 1'b1;
        @(posedge clk);
        io_rd <= 1'b0;
        #1;
        chk("io_rdata", {24'h0, exp}, {24'h0, io_rdata});
    endtask : rd

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    // Bounded wait for the alarm or a reset count
    task automatic wait_alarm(input int lim);
        for (int i = 0; i < lim && alarm_output !== 1'b1; i++) cyc(1);
    endtask : wait_alarm

    task automatic wait_rst(input int n, input int lim);
        for (int i = 0; i < lim && rst_n < n; i++) cyc(1);
    endtask : wait_rst

    // Disable, set durations and control, enable
    task automatic arm(input logic [7:0] dur, input logic [7:0] ctl);
        wr(10'h25F, 8'h00);
        wr(10'h25D, dur);
        wr(10'h25E, ctl);
        wr(10'h25F, 8'h10);
        cyc(2);
    endtask : arm

    task automatic summarize;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize

    initial begin
        #20000;
        bad_count++;
        summarize();
    end

    initial begin
        int base;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        cyc(1);
        chk("alarm after reset", 0, {31'h0, alarm_output});
        rd(10'h25E, 8'h00);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].wd);
            rd(rows[i].a, rows[i].rd);
        end
        // Control must survive the write outside the window
        rd(10'h25E, 8'hA5);
        cyc(4 * T);
        chk("alarm while disabled", 0, {31'h0, alarm_output});
        $display("test register map done");
        // Primary 2 ticks, secondary 1, interrupt and reset on first expiry
        arm(8'h21, 8'h28);
        wr(10'h25C, 8'h10);
        cyc(2 * T);
        chk("alarm before expiry", 0, {31'h0, alarm_output});
        wait_alarm(3 * T);
        cyc(1);
        chk("alarm at expiry", 1, {31'h0, alarm_output});
        chk("smi count", 1, smi_n);
        chk("reset count", 1, rst_n);
        wait_rst(2, 3 * T);
        chk("forced reset", 2, rst_n);
        $display("test cascade done");
        // Nothing selected: only the secondary reset
        arm(8'h31, 8'h00);
        wr(10'h25C, 8'h10);
        wait_alarm(5 * T);
        cyc(1);
        chk("reset none selected", 2, rst_n);
        wait_rst(3, 3 * T);
        chk("unconditional reset", 3, rst_n);
        chk("smi not selected", 1, smi_n);
        $display("test no selection done");
        // Retrigger during secondary countdown; look past where the old second expiry would fall
        arm(8'h32, 8'h00);
        wr(10'h25C, 8'h10);
        wait_alarm(5 * T);
        wr(10'h25C, 8'h10);
        cyc(1);
        chk("alarm after retrigger", 0, {31'h0, alarm_output});
        cyc(2 * T + 2);
        chk("no reset after retrigger", 3, rst_n);
        chk("first countdown reloaded", 0, {31'h0, alarm_output});
        $display("test retrigger done");
        // Early alarm one tick before expiry, then looped back to the trigger pin, rising edges
        arm(8'h31, 8'hD0);
        wr(10'h25C, 8'h10);
        cyc(2 * T);
        chk("alarm before count one", 0, {31'h0, alarm_output});
        cyc(1);
        chk("early alarm", 1, {31'h0, alarm_output});
        loop_en <= 1'b1;
        cyc(20 * T);
        base = rst_n;
        chk("loop keeps alive", 3, base);
        loop_en <= 1'b0;
        level <= 1'b0;
        wait_rst(4, 8 * T);
        chk("broken loop resets", 4, rst_n);
        $display("test loopback done");
        // Falling pin edges retrigger, rising ones do not
        arm(8'h11, 8'h80);
        level <= 1'b1;
        cyc(2 * T + 4);
        chk("rising edge ignored", 0, {31'h0, alarm_output});
        level <= 1'b0;
        wait_alarm(4 * T);
        chk("falling edge start", 1, {31'h0, alarm_output});
        $display("test falling edge done");
        // Reset in mid-run, while the second countdown is pending
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        cyc(1);
        chk("alarm after mid-run reset", 0, {31'h0, alarm_output});
        rd(10'h25F, 8'h00);
        rd(10'h25E, 8'h00);
        cyc(4 * T);
        chk("no reset after mid-run reset", 4, rst_n);
        $display("test mid-run reset done");
        summarize();
    end
endmodule : testbench

`default_nettype wire
